// ==== core/pmc_defines.svh ====
// timing counts, field positions and encodings for the power-mode controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_CTL_ARM_BIT 15
`define PMC_CTL_WIDTH 16
`define PMC_WAKE_WIDTH 16
`define PMC_SCR_WIDTH 16
`define PMC_SAVE_SLEEP 1'b0
`define PMC_SAVE_IDLE 1'b1
`define PMC_ARM_WINDOW_CYC 3'h1
`define PMC_UNLOCK_WINDOW_CYC 3'h5
`define PMC_CTL_RESET 16'h0000
`define PMC_WAKE_RESET 16'h0000
`endif

// ==== core/pmc_pkg.sv ====
// types shared by the power-mode controller files
package pmc_pkg;
   // power modes held by the controller
   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_IDLE,
      PMC_SLEEP,
      PMC_LV_SLEEP,
      PMC_DEEP,
      PMC_RET_DEEP,
      PMC_BATTERY
   } pmc_mode_e;
   // domain enables that leave the controller together
   typedef struct packed {
      logic cpu_run;
      logic periph_sys_clk;
      logic periph_lp_clk;
      logic ram_keep;
      logic flash_power;
      logic io_freeze;
      logic calendar_run;
      logic scratch_keep;
   } pmc_domain_s;
   // wake sources seen by the controller
   typedef struct packed {
      logic any_irq;
      logic irq_zero;
      logic wdt_timeout;
      logic calendar_alarm;
      logic ds_watchdog;
      logic dev_reset;
   } pmc_wake_s;
endpackage

// ==== core/pmc_double_write.sv ====
// double-write lock for one protected register
`timescale 1ns/1ns
module pmc_double_write #(
   parameter int W = 16
) (
   input wire logic mclk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic wr, // write strobe from core
   input wire logic [W-1:0] wdata, // write data
   input wire logic other_wr, // write to another register breaks pairing
   output logic commit, // pulse: second identical write
   output logic [W-1:0] cdata // committed data
);
   logic armed; // first of a pair seen
   logic [W-1:0] first; // data of the first write
   logic next_armed;
   logic [W-1:0] next_first;
   // pair detection: any different write restarts the pair
   always_comb begin
      next_armed = armed;
      next_first = first;
      commit = 1'b0;
      if (wr && !other_wr) begin
         if (armed && wdata == first) begin
            commit = 1'b1;
            next_armed = 1'b0;
         end else begin
            next_armed = 1'b1;
            next_first = wdata;
         end
      end else begin
         // pairs must be back to back: a gap or a clashing write ends the pair
         next_armed = 1'b0;
      end
   end
   assign cdata = first;
   // registers only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         armed <= 1'b0;
         first <= '0;
      end else begin
         armed <= next_armed;
         first <= next_first;
      end
   end
endmodule

// ==== core/pmc_ctrl.sv ====
// power-mode controller: mode state machine, deep-sleep lock, wake and resume
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_ctrl (
   input wire logic mclk, // system clock, 250 MHz
   input wire logic rstn, // async reset, active low
   input wire logic save_req, // pulse: power-save instruction executes
   input wire logic save_kind, // 0 sleep constant, 1 idle constant
   input wire logic instr_step, // pulse: one instruction cycle retired
   input wire logic ctl_wr, // deep-sleep control write strobe
   input wire logic [15:0] ctl_wdata, // deep-sleep control write data
   input wire logic wake_wr, // wake-source register write strobe
   input wire logic [15:0] wake_wdata, // wake-source write data
   input wire logic scr0_wr, // scratch zero write strobe
   input wire logic scr1_wr, // scratch one write strobe
   input wire logic [15:0] scr_wdata, // scratch write data
   input wire logic retention_regulator_enable, // firmware enable bit
   input wire logic retention_config_fuse, // fuse, 0 means programmed
   input wire logic battery_calendar_keep, // 0 excludes calendar in battery
   input wire logic calendar_enable, // firmware enabled the calendar
   input wire pmc_pkg::pmc_wake_s wake_in, // wake events, same clock domain
   input wire logic master_clear_pin, // pin, active high assertion
   input wire logic supply_good, // pin, main supply present
   output pmc_pkg::pmc_mode_e mode, // current power mode
   output pmc_pkg::pmc_domain_s domains, // domain enables
   output logic regulator_on, // retention regulator enabled
   output logic [15:0] deep_sleep_control, // control register
   output logic [15:0] deep_sleep_wake_source, // wake-source register
   output logic [15:0] backup_scratch_zero, // scratch zero
   output logic [15:0] backup_scratch_one, // scratch one
   output logic wake_pulse, // pulse: core resumes
   output logic resume_reset_vector, // resume at reset vector (with wake_pulse)
   output logic service_irq, // pulse: take pending interrupt after wake
   output logic por_reset // pulse: power-on type reset request, held high while master clear is held
);
   // pin synchronisers; first stage read only by second
   logic [1:0] master_clear_pin_sync;
   logic [1:0] vdd_sync;
   logic master_clear_pin_s;
   logic vdd_s;
   logic vdd_prev; // for supply edge detection
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         master_clear_pin_sync <= 2'h0;
         vdd_sync <= 2'h3;
         vdd_prev <= 1'b1;
      end else begin
         master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin};
         vdd_sync <= {vdd_sync[0], supply_good};
         vdd_prev <= vdd_sync[1];
      end
   end
   assign master_clear_pin_s = master_clear_pin_sync[1];
   assign vdd_s = vdd_sync[1];

   // protected register pairing
   logic ctl_commit;
   logic wake_commit;
   logic scr0_commit;
   logic scr1_commit;
   logic [15:0] ctl_cdata;
   logic [15:0] wake_cdata;
   logic [15:0] scr0_cdata;
   logic [15:0] scr1_cdata;
   pmc_double_write #(.W(16)) u_ctl (
      .mclk(mclk), .rstn(rstn), .wr(ctl_wr), .wdata(ctl_wdata),
      .other_wr(wake_wr | scr0_wr | scr1_wr),
      .commit(ctl_commit), .cdata(ctl_cdata));
   pmc_double_write #(.W(16)) u_wake (
      .mclk(mclk), .rstn(rstn), .wr(wake_wr), .wdata(wake_wdata),
      .other_wr(ctl_wr | scr0_wr | scr1_wr),
      .commit(wake_commit), .cdata(wake_cdata));
   pmc_double_write #(.W(16)) u_scr0 (
      .mclk(mclk), .rstn(rstn), .wr(scr0_wr), .wdata(scr_wdata),
      .other_wr(ctl_wr | wake_wr | scr1_wr),
      .commit(scr0_commit), .cdata(scr0_cdata));
   pmc_double_write #(.W(16)) u_scr1 (
      .mclk(mclk), .rstn(rstn), .wr(scr1_wr), .wdata(scr_wdata),
      .other_wr(ctl_wr | wake_wr | scr0_wr),
      .commit(scr1_commit), .cdata(scr1_cdata));

   // regulator is a pure gate of fuse and firmware bit
   assign regulator_on = ~retention_config_fuse & retention_regulator_enable;

   // decode of one request into exactly one target mode
   function automatic pmc_pkg::pmc_mode_e pick_target(input logic kind, input logic arm,
                                                     input logic reg_on);
      if (kind == `PMC_SAVE_IDLE)
         pick_target = pmc_pkg::PMC_IDLE;
      else if (arm && reg_on)
         pick_target = pmc_pkg::PMC_RET_DEEP;
      else if (arm)
         pick_target = pmc_pkg::PMC_DEEP;
      else if (reg_on)
         pick_target = pmc_pkg::PMC_LV_SLEEP;
      else
         pick_target = pmc_pkg::PMC_SLEEP;
   endfunction

   // control state
   pmc_pkg::pmc_mode_e next_mode;
   logic [15:0] next_ctl;
   logic [15:0] next_wake;
   logic [15:0] next_scr0;
   logic [15:0] next_scr1;
   logic [2:0] arm_age; // instruction cycles since arm commit
   logic [2:0] next_arm_age;
   logic irq_held; // interrupt coincident with entry
   logic next_irq_held;
   logic next_wake_pulse;
   logic next_resume_reset;
   logic next_service;
   logic next_por;
   logic arm;
   logic deep_wake;
   logic ss_wake;
   assign arm = deep_sleep_control[`PMC_CTL_ARM_BIT];
   // deep modes ignore general interrupts
   assign deep_wake = wake_in.irq_zero | wake_in.calendar_alarm |
      wake_in.ds_watchdog | wake_in.dev_reset;
   assign ss_wake = wake_in.any_irq | wake_in.wdt_timeout | wake_in.dev_reset;

   // mode machine and protected registers
   always_comb begin
      next_mode = mode;
      next_ctl = deep_sleep_control;
      next_wake = deep_sleep_wake_source;
      next_scr0 = backup_scratch_zero;
      next_scr1 = backup_scratch_one;
      next_arm_age = arm_age;
      next_irq_held = irq_held;
      next_wake_pulse = 1'b0;
      next_resume_reset = resume_reset_vector;
      next_service = 1'b0;
      next_por = 1'b0;
      if (scr0_commit)
         next_scr0 = scr0_cdata;
      if (scr1_commit)
         next_scr1 = scr1_cdata;
      if (wake_commit)
         next_wake = wake_cdata;
      if (ctl_commit) begin
         next_ctl = ctl_cdata;
         next_arm_age = 3'h0;
         if (ctl_cdata[`PMC_CTL_ARM_BIT])
            next_wake = `PMC_WAKE_RESET;
      end else if (arm && instr_step) begin
         // arm expires when the instruction does not follow in time
         if (arm_age >= `PMC_ARM_WINDOW_CYC)
            next_ctl[`PMC_CTL_ARM_BIT] = 1'b0;
         else
            next_arm_age = arm_age + 3'h1;
      end
      // an interrupt inside the unlock window breaks it
      if (arm && wake_in.any_irq && mode == pmc_pkg::PMC_RUN && !save_req)
         next_ctl[`PMC_CTL_ARM_BIT] = 1'b0;
      unique case (mode)
         pmc_pkg::PMC_RUN: begin
            if (save_req) begin
               next_mode = pick_target(save_kind, arm, regulator_on);
               next_irq_held = wake_in.any_irq;
            end
         end
         pmc_pkg::PMC_IDLE, pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_LV_SLEEP: begin
            // held interrupt wakes at once after entry completes
            if (irq_held || ss_wake) begin
               next_mode = pmc_pkg::PMC_RUN;
               next_wake_pulse = 1'b1;
               next_resume_reset = 1'b0;
               next_service = irq_held | wake_in.any_irq;
               next_irq_held = 1'b0;
            end
         end
         pmc_pkg::PMC_DEEP: begin
            if (deep_wake || irq_held) begin
               next_mode = pmc_pkg::PMC_RUN;
               next_wake_pulse = 1'b1;
               next_resume_reset = 1'b1;
               next_por = 1'b1;
               next_irq_held = 1'b0;
               next_ctl[`PMC_CTL_ARM_BIT] = 1'b0;
            end
         end
         pmc_pkg::PMC_RET_DEEP: begin
            if (deep_wake || irq_held) begin
               next_mode = pmc_pkg::PMC_RUN;
               next_wake_pulse = 1'b1;
               next_resume_reset = 1'b0;
               next_service = irq_held;
               next_irq_held = 1'b0;
               next_ctl[`PMC_CTL_ARM_BIT] = 1'b0;
            end
         end
         pmc_pkg::PMC_BATTERY: begin
            // only supply restoration leaves battery mode
            if (vdd_s) begin
               next_mode = pmc_pkg::PMC_RUN;
               next_wake_pulse = 1'b1;
               next_resume_reset = 1'b1;
               next_por = 1'b1;
            end
         end
      endcase
      // supply loss overrides every instruction mode
      if (!vdd_s && vdd_prev) begin
         next_mode = pmc_pkg::PMC_BATTERY;
         next_irq_held = 1'b0;
         next_wake_pulse = 1'b0;
         next_service = 1'b0;
         if (mode != pmc_pkg::PMC_RET_DEEP)
            next_por = 1'b1;
      end
      // master clear wins over everything but supply loss
      if (master_clear_pin_s && vdd_s) begin
         next_mode = pmc_pkg::PMC_RUN;
         next_wake_pulse = mode != pmc_pkg::PMC_RUN;
         next_resume_reset = 1'b1;
         next_por = 1'b1;
         next_service = 1'b0;
         next_irq_held = 1'b0;
         next_ctl = `PMC_CTL_RESET;
      end
   end

   // register stage
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode <= pmc_pkg::PMC_RUN;
         deep_sleep_control <= `PMC_CTL_RESET;
         deep_sleep_wake_source <= `PMC_WAKE_RESET;
         backup_scratch_zero <= 16'h0000;
         backup_scratch_one <= 16'h0000;
         arm_age <= 3'h0;
         irq_held <= 1'b0;
         wake_pulse <= 1'b0;
         resume_reset_vector <= 1'b1;
         service_irq <= 1'b0;
         por_reset <= 1'b0;
      end else begin
         mode <= next_mode;
         deep_sleep_control <= next_ctl;
         deep_sleep_wake_source <= next_wake;
         backup_scratch_zero <= next_scr0;
         backup_scratch_one <= next_scr1;
         arm_age <= next_arm_age;
         irq_held <= next_irq_held;
         wake_pulse <= next_wake_pulse;
         resume_reset_vector <= next_resume_reset;
         service_irq <= next_service;
         por_reset <= next_por;
      end
   end

   // domain enables from the current mode
   always_comb begin
      domains = '0;
      domains.scratch_keep = 1'b1;
      domains.calendar_run = calendar_enable;
      unique case (mode)
         pmc_pkg::PMC_RUN: begin
            domains.cpu_run = 1'b1;
            domains.periph_sys_clk = 1'b1;
            domains.periph_lp_clk = 1'b1;
            domains.ram_keep = 1'b1;
            domains.flash_power = 1'b1;
         end
         pmc_pkg::PMC_IDLE: begin
            domains.periph_sys_clk = 1'b1;
            domains.periph_lp_clk = 1'b1;
            domains.ram_keep = 1'b1;
            domains.flash_power = 1'b1;
         end
         pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_LV_SLEEP: begin
            domains.periph_lp_clk = 1'b1;
            domains.ram_keep = 1'b1;
            domains.flash_power = 1'b1;
            domains.io_freeze = 1'b1;
         end
         pmc_pkg::PMC_DEEP: begin
            domains.io_freeze = 1'b1;
         end
         pmc_pkg::PMC_RET_DEEP: begin
            domains.io_freeze = 1'b1;
            domains.ram_keep = 1'b1;
         end
         pmc_pkg::PMC_BATTERY: begin
            domains.calendar_run = calendar_enable & battery_calendar_keep;
         end
      endcase
   end

   // checks
   plain_deep_vector_a: assert property (@(posedge mclk) disable iff (!rstn)
      (mode == pmc_pkg::PMC_DEEP && next_mode == pmc_pkg::PMC_RUN)
      |=> resume_reset_vector && por_reset) else $error("deep exit not at reset vector");
   ret_deep_entry_a: assert property (@(posedge mclk) disable iff (!rstn)
      (mode == pmc_pkg::PMC_RUN && save_req && save_kind == `PMC_SAVE_SLEEP && arm
       && regulator_on && !master_clear_pin_s && !(vdd_prev && !vdd_s))
      |=> mode == pmc_pkg::PMC_RET_DEEP) else $error("retention deep not entered");
   idle_entry_a: assert property (@(posedge mclk) disable iff (!rstn)
      (mode == pmc_pkg::PMC_RUN && save_req && save_kind == `PMC_SAVE_IDLE
       && !master_clear_pin_s && !(vdd_prev && !vdd_s))
      |=> mode == pmc_pkg::PMC_IDLE ##0 !domains.cpu_run ##0 domains.periph_sys_clk)
      else $error("idle entry wrong");
   held_irq_wake_a: assert property (@(posedge mclk) disable iff (!rstn)
      (mode == pmc_pkg::PMC_RUN && save_req && save_kind == `PMC_SAVE_IDLE && wake_in.any_irq
       && !master_clear_pin_s && vdd_s && vdd_prev)
      |=> ##1 service_irq) else $error("held irq not serviced");
   deep_domains_a: assert property (@(posedge mclk) disable iff (!rstn)
      mode == pmc_pkg::PMC_DEEP |-> domains.io_freeze && !domains.flash_power
      && !domains.ram_keep && !domains.periph_sys_clk) else $error("deep domains wrong");
   master_clear_pin_por_a: assert property (@(posedge mclk) disable iff (!rstn)
      (master_clear_pin_s && vdd_s) |=> por_reset && mode == pmc_pkg::PMC_RUN && resume_reset_vector)
      else $error("master clear no por");
   arm_clears_wake_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctl_commit && ctl_cdata[`PMC_CTL_ARM_BIT] && !master_clear_pin_s)
      |=> deep_sleep_wake_source == 16'h0000) else $error("wake sources not cleared");
   lv_sleep_entry_a: assert property (@(posedge mclk) disable iff (!rstn)
      (mode == pmc_pkg::PMC_RUN && save_req && save_kind == `PMC_SAVE_SLEEP && !arm
       && !retention_config_fuse && retention_regulator_enable && !master_clear_pin_s
       && !(vdd_prev && !vdd_s)) |=> mode == pmc_pkg::PMC_LV_SLEEP)
      else $error("low-voltage sleep not entered");
   irq_breaks_arm_a: assert property (@(posedge mclk) disable iff (!rstn)
      (arm && wake_in.any_irq && mode == pmc_pkg::PMC_RUN && !save_req)
      |=> !deep_sleep_control[`PMC_CTL_ARM_BIT]) else $error("irq did not break unlock");
   single_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      (scr0_wr && !$past(scr0_wr)) |=> $stable(backup_scratch_zero))
      else $error("single write took effect");
   arm_expiry_a: assert property (@(posedge mclk) disable iff (!rstn)
      (arm && instr_step && arm_age >= `PMC_ARM_WINDOW_CYC && !ctl_commit
       && mode == pmc_pkg::PMC_RUN) |=> !deep_sleep_control[`PMC_CTL_ARM_BIT])
      else $error("arm not expired");
endmodule

// ==== verif/pmc_core_model.sv ====
// core-side model: power-save instructions and protected register writes
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_core_model (
   input wire logic mclk, // system clock
   output logic save_req, // power-save instruction pulse
   output logic save_kind, // 0 sleep, 1 idle
   output logic instr_step, // instruction retired pulse
   output logic ctl_wr, // control write strobe
   output logic wake_wr, // wake-source write strobe
   output logic scr0_wr, // scratch zero strobe
   output logic scr1_wr, // scratch one strobe
   output logic [15:0] wdata // shared write data
);
   logic [3:0] stb; // one strobe per protected register
   assign ctl_wr = stb[0];
   assign wake_wr = stb[1];
   assign scr0_wr = stb[2];
   assign scr1_wr = stb[3];
   // quiet core at time zero
   initial begin
      stb = 4'h0;
      save_req = 1'b0;
      save_kind = 1'b0;
      instr_step = 1'b0;
      wdata = 16'h0000;
   end
   // one strobe, or two back-to-back when n > 1, d0 then d1; data inverted once released so no stale value
   task automatic wr(input int sel, input logic [15:0] d0, input logic [15:0] d1, input int n);
      @(posedge mclk);
      stb[sel] <= 1'b1;
      wdata <= d0;
      if (n > 1) begin
         @(posedge mclk);
         wdata <= d1;
      end
      @(posedge mclk);
      stb <= 4'h0;
      wdata <= ~wdata;
   endtask
   // one power-save instruction with its mode constant
   task automatic save(input logic kind);
      @(posedge mclk);
      save_req <= 1'b1;
      save_kind <= kind;
      @(posedge mclk);
      save_req <= 1'b0;
      save_kind <= ~kind;
   endtask
   // arm written twice, sleep constant on the very next cycle, nothing in between
   task automatic deep();
      @(posedge mclk);
      stb[0] <= 1'b1;
      wdata <= 16'h0001 << `PMC_CTL_ARM_BIT;
      @(posedge mclk);
      @(posedge mclk);
      stb <= 4'h0;
      wdata <= 16'h7fff;
      save_req <= 1'b1;
      save_kind <= `PMC_SAVE_SLEEP;
      @(posedge mclk);
      save_req <= 1'b0;
   endtask
   // one retired instruction cycle
   task automatic step();
      @(posedge mclk);
      instr_step <= 1'b1;
      @(posedge mclk);
      instr_step <= 1'b0;
   endtask
endmodule

// ==== verif/pmc_ctrl_bench.sv ====
// self-checking bench for the power-mode controller
`timescale 1ns/1ns
`include "pmc_defines.svh"
module pmc_ctrl_bench;
   localparam logic [15:0] ARM = 16'h0001 << `PMC_CTL_ARM_BIT; // arm bit alone
   logic mclk = 1'b0; // system clock
   logic rstn = 1'b0; // reset, active low
   logic save_req, save_kind, instr_step, ctl_wr, wake_wr, scr0_wr, scr1_wr; // core model
   logic [15:0] wdata; // shared write data
   logic retention_regulator_enable = 1'b0; // firmware bit
   logic retention_config_fuse = 1'b1; // fuse left unprogrammed at first
   logic battery_calendar_keep = 1'b0; // calendar dropped in battery
   logic calendar_enable = 1'b1; // calendar on
   pmc_pkg::pmc_wake_s wake_in = '0; // wake events
   logic master_clear_pin = 1'b0; // pin idle
   logic supply_good = 1'b1; // supply present
   pmc_pkg::pmc_mode_e mode; // mode seen
   pmc_pkg::pmc_domain_s domains; // domains seen
   logic regulator_on, wake_pulse, resume_reset_vector, service_irq, por_reset;
   logic [15:0] deep_sleep_control, deep_sleep_wake_source, backup_scratch_zero;
   logic [15:0] backup_scratch_one;
   pmc_pkg::pmc_mode_e exp_mode = pmc_pkg::PMC_RUN; // model: expected mode
   logic exp_rrv_q[$]; // model: resume vector expected per wake
   int exp_por = 0, exp_srv = 0, n_por = 0, n_srv = 0; // pulse counts
   int n_fail = 0, n_tests = 0, cycles = 0;
   logic [15:0] r0; // random scratch value
   logic por_q = 1'b0; // por seen on the previous edge; a held reset counts once
   always #2 mclk = ~mclk;
   pmc_core_model i_pmc_core_model (.mclk, .save_req, .save_kind, .instr_step, .ctl_wr,
      .wake_wr, .scr0_wr, .scr1_wr, .wdata);
   pmc_ctrl i_pmc_ctrl (.mclk, .rstn, .save_req, .save_kind, .instr_step, .ctl_wr,
      .ctl_wdata(wdata), .wake_wr, .wake_wdata(wdata), .scr0_wr, .scr1_wr, .scr_wdata(wdata),
      .retention_regulator_enable, .retention_config_fuse, .battery_calendar_keep,
      .calendar_enable, .wake_in, .master_clear_pin, .supply_good, .mode, .domains,
      .regulator_on, .deep_sleep_control, .deep_sleep_wake_source, .backup_scratch_zero,
      .backup_scratch_one, .wake_pulse, .resume_reset_vector, .service_irq, .por_reset);
   // compare one value, four-state exact
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_mode();
      chk("mode", 16'(exp_mode), 16'(mode));
   endtask
   // let edges pass, then step off the edge so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulse_wake(input logic [5:0] w);
      @(posedge mclk);
      wake_in <= pmc_pkg::pmc_wake_s'(w);
      @(posedge mclk);
      wake_in <= '0;
   endtask
   // wake event with the resume vector the model expects
   task automatic wake(input logic [5:0] w, input logic rrv);
      exp_rrv_q.push_back(rrv);
      exp_mode = pmc_pkg::PMC_RUN;
      // an interrupt that wakes the core is also taken
      if (w[5]) exp_srv++;
      pulse_wake(w);
      cyc(5);
      chk_mode();
      chk("woke", 16'h0000, 16'(exp_rrv_q.size()));
   endtask
   task automatic endt(input string s);
      $display("test %s done", s);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // pulse monitor; wake_pulse and service_irq stand one cycle, so each edge sees each once; por_reset stays high while master clear is held
   always @(posedge mclk) begin
      if (wake_pulse === 1'b1 && exp_rrv_q.size() > 0) begin
         chk("resume", 16'(exp_rrv_q.pop_front()), 16'(resume_reset_vector));
      end
      if (por_reset === 1'b1 && por_q !== 1'b1) n_por++;
      por_q <= por_reset;
      if (service_irq === 1'b1) n_srv++;
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         complete_run();
      end
   end
   // main sequence
   initial begin
      void'($urandom(32'hc9b3));
      r0 = 16'($urandom) | 16'h0001;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      cyc(2);
      chk_mode();
      chk("ctl", `PMC_CTL_RESET, deep_sleep_control);
      chk("wake", `PMC_WAKE_RESET, deep_sleep_wake_source);
      chk("vector", 16'h0001, 16'(resume_reset_vector));
      endt("reset");
      i_pmc_core_model.save(`PMC_SAVE_IDLE);
      exp_mode = pmc_pkg::PMC_IDLE;
      cyc(2);
      chk_mode();
      chk("idle dom", 16'h0003,
         16'({domains.cpu_run, domains.periph_sys_clk, domains.ram_keep}));
      wake(6'h20, 1'b0);
      endt("idle");
      // plain sleep woken by watchdog, then low-voltage sleep woken by interrupt
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) retention_regulator_enable <= i[0];
         retention_config_fuse <= 1'b0;
         cyc(1);
         chk("reg on", 16'(i), 16'(regulator_on));
         i_pmc_core_model.save(`PMC_SAVE_SLEEP);
         exp_mode = i ? pmc_pkg::PMC_LV_SLEEP : pmc_pkg::PMC_SLEEP;
         cyc(2);
         chk_mode();
         chk("sleep dom", 16'h0001,
            16'({domains.cpu_run, domains.periph_sys_clk, domains.ram_keep}));
         wake(i ? 6'h20 : 6'h08, 1'b0);
      end
      @(posedge mclk) retention_config_fuse <= 1'b1;
      cyc(1);
      chk("reg fuse", 16'h0000, 16'(regulator_on));
      endt("sleep");
      // interrupt on the instruction itself is held, then wakes and is serviced
      exp_rrv_q.push_back(1'b0);
      exp_srv++;
      fork
         i_pmc_core_model.save(`PMC_SAVE_IDLE);
         pulse_wake(6'h20);
      join
      cyc(6);
      chk("held irq", 16'(exp_srv), 16'(n_srv));
      chk("held wake", 16'h0000, 16'(exp_rrv_q.size()));
      endt("held");
      // single, mismatched and paired writes to both scratch registers
      for (int s = 2; s < 4; s++) begin
         i_pmc_core_model.wr(s, r0, r0, 1);
         cyc(1);
         chk("scr single", 16'h0000, s == 2 ? backup_scratch_zero : backup_scratch_one);
         i_pmc_core_model.wr(s, r0, ~r0, 2);
         cyc(1);
         chk("scr differ", 16'h0000, s == 2 ? backup_scratch_zero : backup_scratch_one);
         i_pmc_core_model.wr(s, r0, r0, 2);
         cyc(1);
         chk("scr pair", r0, s == 2 ? backup_scratch_zero : backup_scratch_one);
      end
      i_pmc_core_model.wr(1, 16'h0001, 16'h0001, 2);
      cyc(1);
      chk("wake set", 16'h0001, deep_sleep_wake_source);
      i_pmc_core_model.wr(0, ARM, ARM, 2);
      cyc(1);
      chk("wake clr", 16'h0000, deep_sleep_wake_source);
      i_pmc_core_model.step();
      cyc(1);
      chk("arm grace", ARM, deep_sleep_control);
      i_pmc_core_model.step();
      cyc(1);
      chk("arm lapse", 16'h0000, deep_sleep_control);
      i_pmc_core_model.wr(0, ARM, ARM, 2);
      pulse_wake(6'h20);
      cyc(1);
      chk("arm irq", 16'h0000, deep_sleep_control);
      endt("writes");
      // plain then retention deep sleep; general interrupt must not wake
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) retention_config_fuse <= 1'b0;
         retention_regulator_enable <= i[0];
         i_pmc_core_model.deep();
         exp_mode = i ? pmc_pkg::PMC_RET_DEEP : pmc_pkg::PMC_DEEP;
         cyc(2);
         chk_mode();
         chk("deep dom", i ? 16'h0005 : 16'h0001, 16'({domains.cpu_run,
            domains.periph_sys_clk, domains.ram_keep, domains.flash_power, domains.io_freeze}));
         chk("calendar", 16'h0001, 16'(domains.calendar_run));
         pulse_wake(6'h28);
         cyc(3);
         chk_mode();
         exp_por += 1 - i;
         wake(i ? 6'h04 : 6'h10, ~i[0]);
         chk("arm exit", 16'h0000, deep_sleep_control);
         chk("por", 16'(exp_por), 16'(n_por));
      end
      endt("deep");
      // interrupt coincident with deep entry: lost without retention, serviced with it
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) retention_regulator_enable <= i[0];
         exp_rrv_q.push_back(~i[0]);
         exp_por += 1 - i;
         exp_srv += i;
         fork
            i_pmc_core_model.deep();
            begin
               repeat (2) @(posedge mclk);
               pulse_wake(6'h20);
            end
         join
         cyc(8);
         exp_mode = pmc_pkg::PMC_RUN;
         chk_mode();
         chk("por", 16'(exp_por), 16'(n_por));
         chk("serviced", 16'(exp_srv), 16'(n_srv));
         chk("woke", 16'h0000, 16'(exp_rrv_q.size()));
      end
      endt("coincident");
      i_pmc_core_model.save(`PMC_SAVE_SLEEP);
      cyc(2);
      exp_rrv_q.push_back(1'b1);
      @(posedge mclk) master_clear_pin <= 1'b1;
      cyc(4);
      @(posedge mclk) master_clear_pin <= 1'b0;
      cyc(6);
      exp_por++;
      chk_mode();
      chk("master_clear_pin por", 16'(exp_por), 16'(n_por));
      chk("master_clear_pin woke", 16'h0000, 16'(exp_rrv_q.size()));
      endt("master clear");
      @(posedge mclk) supply_good <= 1'b0;
      exp_mode = pmc_pkg::PMC_BATTERY;
      exp_por++;
      cyc(5);
      chk_mode();
      chk("bat dom", 16'h0001, 16'({domains.calendar_run, domains.scratch_keep}));
      exp_rrv_q.push_back(1'b1);
      @(posedge mclk) supply_good <= 1'b1;
      exp_por++;
      exp_mode = pmc_pkg::PMC_RUN;
      cyc(6);
      chk_mode();
      chk("supply por", 16'(exp_por), 16'(n_por));
      chk("supply woke", 16'h0000, 16'(exp_rrv_q.size()));
      endt("supply");
      complete_run();
   end
endmodule
